// ### rtl/sei_consts.svh
`ifndef SEI_CONSTS_SVH
`define SEI_CONSTS_SVH

// Instruction codes
`define SEI_OP_READ 8'h03
`define SEI_OP_WRITE 8'h02
`define SEI_OP_LCLR 8'h04
`define SEI_OP_LSET 8'h06
`define SEI_OP_SRD 8'h05
`define SEI_OP_SWR 8'h01

// Status field positions
`define SEI_SR_PIN_EN 7
`define SEI_SR_GUARD_HI 3
`define SEI_SR_GUARD_LO 2
`define SEI_SR_LATCH 1
`define SEI_SR_BUSY 0

// Reset values
`define SEI_SR_PIN_EN_RST 1'b0
`define SEI_SR_GUARD_RST 2'b00
`define SEI_LATCH_RST 1'b0

// Array geometry
`define SEI_ADDR_W 13
`define SEI_PAGE_BYTES 32
`define SEI_PAGE_W 5
`define SEI_ADDR_TOP 13'h1fff
`define SEI_QUARTER_BASE 13'h1800
`define SEI_HALF_BASE 13'h1000
`define SEI_FIFO_DEPTH 32

// Timing
`define SEI_CLK_HZ 25000000
`define SEI_TWC_MS 5
`define SEI_TWC_CYCLES (`SEI_CLK_HZ / 1000 * `SEI_TWC_MS)
`define SEI_CNT_W 20

`endif

// ### rtl/sei_pkg.sv
package sei_pkg;

  typedef enum logic [2:0] {
    SEI_PH_OPC = 3'b000,
    SEI_PH_AHI = 3'b001,
    SEI_PH_ALO = 3'b011,
    SEI_PH_DATA = 3'b010,
    SEI_PH_IGN = 3'b110
  } sei_phase_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
  } sei_pins_t;

  typedef struct packed {
    logic pin_en;
    logic [1:0] guard;
  } sei_nv_t;

endpackage : sei_pkg

// ### rtl/sei_fifo.sv
`timescale 1ns/1ps

module sei_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = !((wr_q[AW] != rd_q[AW]) &&
                      (wr_q[AW-1:0] == rd_q[AW-1:0]));
  assign out_valid = (wr_q != rd_q);
  assign out_data = mem[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else if (clear) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

endmodule : sei_fifo

// ### rtl/sei_top.sv
`timescale 1ns/1ps
`include "sei_consts.svh"

module sei_top
  import sei_pkg::*;
#(
  parameter int WRITE_CYCLES = `SEI_TWC_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  input wire logic HOLD_N,
  input wire logic WP_N,
  output logic SO,
  output logic SO_OE
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers

  logic rst_s1_q;
  logic rst_n_q;
  sei_pins_t pins_s1_q;
  sei_pins_t pins_q;
  logic sck_d_q;
  logic cs_d_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  localparam sei_pins_t PINS_IDLE = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0,
                                      hold_n: 1'b1, wp_n: 1'b1};
  wire sei_pins_t pins_raw = '{cs_n: CS_N, sck: SCK, si: SI,
                               hold_n: HOLD_N, wp_n: WP_N};

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pins_s1_q <= PINS_IDLE;
      pins_q <= PINS_IDLE;
      sck_d_q <= 1'b0;
      cs_d_q <= 1'b1;
    end else begin
      pins_s1_q <= pins_raw;
      pins_q <= pins_s1_q;
      sck_d_q <= pins_q.sck;
      cs_d_q <= pins_q.cs_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic guarded(input logic [1:0] g,
                                   input logic [`SEI_ADDR_W-1:0] a);
    unique case (g)
      2'b00: guarded = 1'b0;
      2'b01: guarded = (a >= `SEI_QUARTER_BASE);
      2'b10: guarded = (a >= `SEI_HALF_BASE);
      2'b11: guarded = 1'b1;
    endcase
  endfunction : guarded

  ////////////////////////////////////////////////////////////////////////////
  // Pause control and edge qualification

  logic paused_q;

  wire selected = !pins_q.cs_n;
  wire cs_rise = pins_q.cs_n && !cs_d_q;
  wire sck_hi_raw = pins_q.sck && !sck_d_q;
  wire sck_lo_raw = !pins_q.sck && sck_d_q;
  wire active = selected && pins_q.hold_n && !paused_q;
  wire sck_rise = active && sck_hi_raw;
  wire sck_fall = active && sck_lo_raw;
  wire pause_go = !pins_q.hold_n && (!pins_q.sck || sck_lo_raw);
  wire pause_end = pins_q.hold_n && !pins_q.sck;

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      paused_q <= 1'b0;
    end else if (!selected) begin
      paused_q <= 1'b0;
    end else if (!paused_q) begin
      paused_q <= pause_go;
    end else if (pause_end) begin
      paused_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial receive and instruction decode

  sei_phase_t phase_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] opc_q;
  logic [`SEI_ADDR_W-1:0] addr_q;
  logic got_q;
  logic [7:0] sr_new_q;
  logic busy_q;
  logic latch_q;
  sei_nv_t nv_q;

  wire [7:0] sh_d = {sh_q[6:0], pins_q.si};
  wire byte_done = sck_rise && (bit_q == 3'd7);
  wire op_rd = (sh_d == `SEI_OP_READ);
  wire op_wr = (sh_d == `SEI_OP_WRITE);
  wire op_srd = (sh_d == `SEI_OP_SRD);
  wire op_other = (sh_d == `SEI_OP_SWR) || (sh_d == `SEI_OP_LSET) ||
                  (sh_d == `SEI_OP_LCLR);
  wire is_rd = (opc_q == `SEI_OP_READ);
  wire is_wr = (opc_q == `SEI_OP_WRITE);
  wire is_srd = (opc_q == `SEI_OP_SRD);
  wire is_swr = (opc_q == `SEI_OP_SWR);
  wire frame_ok = (phase_q == SEI_PH_DATA) && (bit_q == 3'd0);

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      phase_q <= SEI_PH_OPC;
      bit_q <= 3'd0;
      sh_q <= 8'h00;
      opc_q <= 8'h00;
      addr_q <= '0;
      got_q <= 1'b0;
      sr_new_q <= 8'h00;
    end else if (!selected) begin
      phase_q <= SEI_PH_OPC;
      bit_q <= 3'd0;
      got_q <= 1'b0;
    end else if (sck_rise) begin
      bit_q <= bit_q + 3'd1;
      sh_q <= sh_d;
      if (byte_done) begin
        unique case (phase_q)
          SEI_PH_OPC: begin
            opc_q <= sh_d;
            if (op_srd) begin
              phase_q <= SEI_PH_DATA;
            end else if (busy_q) begin
              phase_q <= SEI_PH_IGN;
            end else if (op_rd || op_wr) begin
              phase_q <= SEI_PH_AHI;
            end else if (op_other) begin
              phase_q <= SEI_PH_DATA;
            end else begin
              phase_q <= SEI_PH_IGN;
            end
          end
          SEI_PH_AHI: begin
            addr_q[`SEI_ADDR_W-1:8] <= sh_d[`SEI_ADDR_W-9:0];
            phase_q <= SEI_PH_ALO;
          end
          SEI_PH_ALO: begin
            addr_q[7:0] <= sh_d;
            phase_q <= SEI_PH_DATA;
          end
          SEI_PH_DATA: begin
            got_q <= 1'b1;
            if (is_swr && !got_q) begin
              sr_new_q <= sh_d;
            end
            if (is_wr) begin
              addr_q[`SEI_PAGE_W-1:0] <=
                addr_q[`SEI_PAGE_W-1:0] + 1'b1;
            end
          end
          SEI_PH_IGN: begin
            phase_q <= SEI_PH_IGN;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array, page buffer and internal write cycle

  logic [7:0] mem [2**`SEI_ADDR_W];
  logic [7:0] page_buf [`SEI_PAGE_BYTES];
  logic [`SEI_PAGE_BYTES-1:0] mask_q;
  logic [`SEI_ADDR_W-`SEI_PAGE_W-1:0] page_q;
  logic [`SEI_CNT_W-1:0] cnt_q;

  wire wr_byte = byte_done && (phase_q == SEI_PH_DATA) && is_wr;
  wire [`SEI_PAGE_W-1:0] cp_idx = cnt_q[`SEI_PAGE_W-1:0];
  wire cp_phase = (cnt_q < `SEI_CNT_W'(`SEI_PAGE_BYTES));
  wire hw_lock = !pins_q.wp_n && nv_q.pin_en;
  wire page_locked = guarded(nv_q.guard, addr_q);
  wire go_array = cs_rise && !busy_q && frame_ok && is_wr && got_q &&
                  latch_q && !page_locked;
  wire go_status = cs_rise && !busy_q && frame_ok && is_swr && got_q &&
                   latch_q && !hw_lock;
  wire cyc_end = busy_q && (cnt_q == `SEI_CNT_W'(WRITE_CYCLES - 1));
  wire go_set = cs_rise && frame_ok && !got_q && (opc_q == `SEI_OP_LSET);
  wire go_clr = cs_rise && frame_ok && !got_q && (opc_q == `SEI_OP_LCLR);

  always_ff @(posedge CLK) begin
    if (wr_byte) begin
      page_buf[addr_q[`SEI_PAGE_W-1:0]] <= sh_d;
    end
    if (busy_q && cp_phase && mask_q[cp_idx]) begin
      mem[{page_q, cp_idx}] <= page_buf[cp_idx];
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      mask_q <= '0;
      page_q <= '0;
    end else if (wr_byte) begin
      mask_q[addr_q[`SEI_PAGE_W-1:0]] <= 1'b1;
      page_q <= addr_q[`SEI_ADDR_W-1:`SEI_PAGE_W];
    end else if ((cs_rise && !go_array && !busy_q) || cyc_end) begin
      mask_q <= '0;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      busy_q <= 1'b0;
      cnt_q <= '0;
    end else if (go_array || go_status) begin
      busy_q <= 1'b1;
      cnt_q <= '0;
    end else if (cyc_end) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      nv_q <= '{pin_en: `SEI_SR_PIN_EN_RST, guard: `SEI_SR_GUARD_RST};
    end else if (go_status) begin
      nv_q.pin_en <= sr_new_q[`SEI_SR_PIN_EN];
      nv_q.guard <= sr_new_q[`SEI_SR_GUARD_HI:`SEI_SR_GUARD_LO];
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      latch_q <= `SEI_LATCH_RST;
    end else if (go_set) begin
      latch_q <= 1'b1;
    end else if (go_clr || cyc_end) begin
      latch_q <= 1'b0;
    end
  end

  wire [7:0] status = {nv_q.pin_en, 3'b000, nv_q.guard, latch_q,
                       busy_q};

  ////////////////////////////////////////////////////////////////////////////
  // Read prefetch into the output FIFO

  logic fill_q;
  logic [`SEI_ADDR_W-1:0] rd_ptr_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;

  wire rd_start = byte_done && (phase_q == SEI_PH_ALO) && is_rd;
  wire push = fill_q && fifo_in_ready;

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fill_q <= 1'b0;
      rd_ptr_q <= '0;
    end else if (!selected) begin
      fill_q <= 1'b0;
    end else if (rd_start) begin
      fill_q <= 1'b1;
      rd_ptr_q <= {addr_q[`SEI_ADDR_W-1:8], sh_d};
    end else if (push) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial transmit

  logic [7:0] tx_q;
  logic tx_on_q;
  logic so_q;
  logic so_oe_q;

  wire tx_mode = (phase_q == SEI_PH_DATA) && (is_rd || is_srd);
  wire tx_load = sck_fall && tx_mode && (bit_q == 3'd0);
  wire pop = tx_load && is_rd;
  wire [7:0] tx_byte = is_srd ? status : fifo_out_data;

  sei_fifo #(
    .WIDTH(8),
    .DEPTH(`SEI_FIFO_DEPTH)
  ) u_fifo (
    .clk(CLK),
    .rst_n(rst_n_q),
    .clear(!selected),
    .in_valid(fill_q),
    .in_ready(fifo_in_ready),
    .in_data(mem[rd_ptr_q]),
    .out_valid(fifo_out_valid),
    .out_ready(pop),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_q <= 8'h00;
      tx_on_q <= 1'b0;
      so_q <= 1'b0;
    end else if (!selected) begin
      tx_on_q <= 1'b0;
    end else if (tx_load) begin
      so_q <= tx_byte[7];
      tx_q <= {tx_byte[6:0], 1'b0};
      tx_on_q <= 1'b1;
    end else if (sck_fall && tx_on_q) begin
      so_q <= tx_q[7];
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  always_ff @(posedge CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      so_oe_q <= 1'b0;
    end else begin
      so_oe_q <= selected && pins_q.hold_n && !paused_q &&
                 (tx_on_q || tx_load);
    end
  end

  assign SO = so_q;
  assign SO_OE = so_oe_q;

endmodule : sei_top

// ### verification/sei_top_chk.sv
`timescale 1ns/1ps
module sei_chk (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  input wire logic HOLD_N,
  input wire logic WP_N,
  input wire logic SO,
  input wire logic SO_OE
);
  logic sck_q;
  logic [7:0] age_q;
  logic [7:0] age_d;
  logic [7:0] rise_q;
  logic [7:0] rise_d;
  wire sck_fall = sck_q && !SCK;
  wire sck_rise = !sck_q && SCK;
  // Cycles since a raw clock fall, rises since select
  assign age_d = sck_fall ? 8'h00 : age_q + {7'h00, age_q != 8'hff};
  assign rise_d = CS_N ? 8'h00 :
    rise_q + {7'h00, sck_rise && rise_q != 8'hff};
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_q <= 1'b0;
      age_q <= 8'hff;
      rise_q <= 8'h00;
    end else begin
      sck_q <= SCK;
      age_q <= age_d;
      rise_q <= rise_d;
    end
  end
  default clocking dc @(posedge CLK);
  endclocking
  sequence s_so_move;
    SO_OE && $past(SO_OE) && $changed(SO);
  endsequence
  sequence s_hold_long;
    (!HOLD_N) [*6];
  endsequence
  sequence s_desel_long;
    CS_N [*6];
  endsequence
  a_so_after_fall: assert property (
    disable iff (!RST_N) s_so_move |-> age_q <= 8'h06)
    else $error("SO moved without a clock fall");
  a_hold_float: assert property (
    disable iff (!RST_N) $fell(HOLD_N) |-> ##[1:5] !SO_OE)
    else $error("SO not floated after pause");
  a_hold_still: assert property (
    disable iff (!RST_N) s_hold_long |-> !SO_OE)
    else $error("SO driven while paused");
  a_desel_float: assert property (
    disable iff (!RST_N) s_desel_long |-> !SO_OE)
    else $error("SO driven while deselected");
  a_oe_opcode: assert property (
    disable iff (!RST_N) $rose(SO_OE) |-> rise_q >= 8'h08)
    else $error("SO driven before a full opcode");
  a_oe_count: assert property (
    disable iff (!RST_N) $rose(SO_OE) && age_q <= 8'h06 |->
    rise_q inside {[8'h08:8'h09], [8'h18:8'h19]})
    else $error("SO started at a wrong bit count");
  a_oe_sel: assert property (
    disable iff (!RST_N) $rose(SO_OE) |-> !CS_N && HOLD_N)
    else $error("SO started while not selected");
  a_reset_quiet: assert property (
    !RST_N && rise_q == 8'h00 |-> !SO_OE && !SO)
    else $error("SO active in reset");
endmodule : sei_chk

bind sei_top sei_chk u_chk (
  .CLK(CLK), .RST_N(RST_N), .CS_N(CS_N), .SCK(SCK), .SI(SI),
  .HOLD_N(HOLD_N), .WP_N(WP_N), .SO(SO), .SO_OE(SO_OE)
);

// ### verification/sei_host.sv
`timescale 1ns/1ps
module sei_host
  import sei_pkg::*;
(
  input wire logic clk,
  output sei_pins_t pins,
  input wire logic so,
  input wire logic so_oe
);
  logic last_q = 1'b0;
  logic seen = 1'b0;
  logic hold_oe = 1'b1;
  // Released line shows the inverse of its last value
  wire so_w = so_oe ? so : ~last_q;
  initial pins = 5'h13;
  always @(posedge clk) begin
    if (so_oe) last_q <= so;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic sel();
    pins.cs_n = 1'b0;
    tick(4);
  endtask : sel
  task automatic desel();
    pins.sck = 1'b0;
    tick(4);
    pins.cs_n = 1'b1;
    tick(8);
  endtask : desel
  task automatic byte_io(input logic [7:0] tx, input int hb, input int lo,
                         output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i >= lo; i--) begin
      pins.sck = 1'b0;
      pins.si = tx[i];
      tick(4);
      if (i == hb) begin
        pins.hold_n = 1'b0;
        tick(8);
        hold_oe = so_oe;
        pins.sck = 1'b1;
        pins.si = ~tx[i];
        tick(4);
        pins.sck = 1'b0;
        pins.si = tx[i];
        tick(8);
        pins.hold_n = 1'b1;
        tick(8);
      end
      seen = seen | so_oe;
      rx[i] = so_w;
      pins.sck = 1'b1;
      tick(4);
    end
  endtask : byte_io
endmodule : sei_host

// ### verification/sei_top_tb_top.sv
`timescale 1ns/1ps
`include "sei_consts.svh"
module sei_top_tb_top import sei_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  sei_pins_t pins;
  logic so;
  logic so_oe;
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  int hold_at = -1;
  int num_errors = 0;
  int num_checks = 0;
  always #20 clk = ~clk;
  sei_top #(.WRITE_CYCLES(400)) dut (
    .CLK(clk), .RST_N(rst_n), .CS_N(pins.cs_n), .SCK(pins.sck),
    .SI(pins.si), .HOLD_N(pins.hold_n), .WP_N(pins.wp_n),
    .SO(so), .SO_OE(so_oe)
  );
  sei_host u_host (.clk(clk), .pins(pins), .so(so), .so_oe(so_oe));
  ////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (num_errors == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask : chk8
  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask : chk1
  task automatic run(input int lo);
    logic [7:0] r;
    int hb;
    rx_q = {};
    u_host.sel();
    foreach (tx_q[k]) begin
      hb = (k == hold_at) ? 3 : 8;
      u_host.byte_io(tx_q[k], hb, (k == tx_q.size() - 1) ? lo : 0, r);
      rx_q.push_back(r);
    end
    u_host.desel();
  endtask : run
  task automatic op1(input logic [7:0] o);
    tx_q = '{o};
    run(0);
  endtask : op1
  task automatic st(input logic [7:0] e);
    tx_q = '{`SEI_OP_SRD, 8'h00};
    run(0);
    chk8(rx_q[1], e);
  endtask : st
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      tx_q = '{`SEI_OP_SRD, 8'h00};
      run(0);
      n++;
    end while (rx_q[1][0] !== 1'b0 && n < 10);
    if (rx_q[1][0] !== 1'b0) begin
      num_errors++;
      $display("Error at %0t: write cycle never ended", $time);
      end_sim();
    end
  endtask : wait_idle
  function automatic logic [7:0] guard_base(input int g);
    return (g == 1) ? 8'h18 : (g == 2) ? 8'h10 : 8'h00;
  endfunction : guard_base
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    u_host.tick(8);
    st(8'h00);
    op1(`SEI_OP_LSET);
    st(8'h02);
    op1(`SEI_OP_LCLR);
    st(8'h00);
    tx_q = '{`SEI_OP_LSET};
    run(1);
    st(8'h00);
    tx_q = '{`SEI_OP_LSET, `SEI_OP_WRITE, 8'h00, 8'h00, 8'haa};
    run(0);
    st(8'h00);
    op1(`SEI_OP_LSET);
    tx_q = '{`SEI_OP_WRITE, 8'h00, 8'h1f, 8'h11, 8'h22};
    run(0);
    st(8'h03);
    u_host.seen = 1'b0;
    tx_q = '{`SEI_OP_READ, 8'h00, 8'h1f, 8'h00};
    run(0);
    chk1(u_host.seen, 1'b0);
    wait_idle();
    st(8'h00);
    op1(`SEI_OP_LSET);
    tx_q = '{`SEI_OP_WRITE, 8'hff, 8'hff, 8'h33};
    run(0);
    wait_idle();
    hold_at = 3;
    tx_q = '{`SEI_OP_READ, 8'hff, 8'hff, 8'h00, 8'h00};
    run(0);
    hold_at = -1;
    chk1(u_host.hold_oe, 1'b0);
    chk8(rx_q[3], 8'h33);
    chk8(rx_q[4], 8'h22);
    tx_q = '{`SEI_OP_READ, 8'he0, 8'h1f, 8'h00};
    run(0);
    chk8(rx_q[3], 8'h11);
    op1(`SEI_OP_LSET);
    tx_q = '{`SEI_OP_WRITE, 8'h00, 8'h1f, 8'h55};
    run(4);
    st(8'h02);
    tx_q = '{8'h07, `SEI_OP_LCLR};
    run(0);
    st(8'h02);
    for (int g = 1; g < 4; g++) begin
      tx_q = '{`SEI_OP_SWR, 8'(g << 2)};
      run(0);
      wait_idle();
      op1(`SEI_OP_LSET);
      tx_q = '{`SEI_OP_WRITE, guard_base(g), 8'h00, 8'h77};
      run(0);
      st(8'(g << 2) | 8'h02);
    end
    tx_q = '{`SEI_OP_SWR, 8'h84};
    run(0);
    wait_idle();
    st(8'h84);
    u_host.pins.wp_n = 1'b0;
    op1(`SEI_OP_LSET);
    tx_q = '{`SEI_OP_SWR, 8'h0c};
    run(0);
    st(8'h86);
    u_host.pins.wp_n = 1'b1;
    tx_q = '{`SEI_OP_SWR, 8'h0c};
    run(0);
    wait_idle();
    st(8'h0c);
    op1(`SEI_OP_LSET);
    u_host.pins.wp_n = 1'b0;
    tx_q = '{`SEI_OP_SWR, 8'h00};
    run(0);
    wait_idle();
    u_host.pins.wp_n = 1'b1;
    st(8'h00);
    end_sim();
  end
endmodule : sei_top_tb_top
